// ### shared/ocsd_pkg.sv
/*
 * Shared constants and types for the output channel source and
 * divider block: register map, field layout, reset values, source
 * and driver encodings, bus responses and the driver state carrier.
 * Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
 */
package ocsd_pkg;

	// ****************************************************
	// register map
	// ****************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_IDX_DIV4 = 8'h26;
	localparam logic [ADDR_W-1:0] REG_IDX_CTL5 = 8'h27;
	localparam logic [ADDR_W-1:0] REG_IDX_STAT = 8'h28;
	// byte address is four times the register index
	localparam logic [ADDR_W-1:0] ADDR_DIV4 = 8'(REG_IDX_DIV4 * 4);
	localparam logic [ADDR_W-1:0] ADDR_CTL5 = 8'(REG_IDX_CTL5 * 4);
	localparam logic [ADDR_W-1:0] ADDR_STAT = 8'(REG_IDX_STAT * 4);

	// decoded register selector
	localparam logic [1:0] SEL_DIV4 = 2'h0;
	localparam logic [1:0] SEL_CTL5 = 2'h1;
	localparam logic [1:0] SEL_STAT = 2'h2;
	localparam logic [1:0] SEL_NONE = 2'h3;

	// ****************************************************
	// field layout and reset values
	// ****************************************************
	localparam int CTL_SRC_LSB = 6;
	localparam int CTL_DRV_LSB = 4;
	localparam int CTL_OPTA_LSB = 2;
	localparam int CTL_OPTB_LSB = 0;
	localparam int STAT_SRC5_LSB = 6;
	localparam int STAT_SRC4_LSB = 4;
	localparam logic [7:0] DIV4_RESET = 8'h02;
	localparam logic [1:0] SRC5_RESET = 2'h0;
	localparam logic [1:0] DRV5_RESET = 2'h1;
	localparam logic [1:0] OPTA5_RESET = 2'h2;
	localparam logic [1:0] OPTB5_RESET = 2'h0;

	// ****************************************************
	// encodings
	// ****************************************************
	localparam logic [1:0] SRC_PLL = 2'h0;
	localparam logic [1:0] SRC_RSVD = 2'h1;
	localparam logic [1:0] SRC_PRI = 2'h2;
	localparam logic [1:0] SRC_SEC = 2'h3;
	localparam logic [1:0] DRV_OFF = 2'h0;
	localparam logic [1:0] DRV_DIFF = 2'h1;
	localparam logic [1:0] DRV_HCSL = 2'h2;
	localparam logic [1:0] DRV_CMOS = 2'h3;
	// cmos pin option: tristate, low, inverted, normal
	localparam logic [1:0] PIN_TRI = 2'h0;
	localparam logic [1:0] PIN_LOW = 2'h1;
	localparam logic [1:0] PIN_INV = 2'h2;
	localparam logic [1:0] PIN_NORM = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// write channel states, one-hot
	typedef enum logic [1:0] {
		WR_TAKE = 2'b01,
		WR_RESP = 2'b10
	} ocsd_wr_e;

	// output driver state of one channel
	typedef struct packed {
		logic oe_p;
		logic out_p;
		logic oe_n;
		logic out_n;
		logic [1:0] tail_code;
		logic [1:0] load_code;
	} ocsd_drv_s;

endpackage

// ### design/ocsd_divider.sv
/*
 * Output divider of one channel: divides a sampled source level by
 * the stored value plus one, or passes it through when bypassed.
 * Assumes the source level is synchronous to clk and at most half
 * its rate, so every source edge is seen.
 */
`timescale 1ns/1ps
module ocsd_divider
	import ocsd_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic src_level,
	input wire logic [7:0] div_value,
	input wire logic bypass,
	output logic clk_out
);

	logic src_q_r;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [7:0] ratio_r;
	logic [7:0] ratio_nxt;
	logic [8:0] half;
	logic rise;
	logic wrap;

	// source rising edge and divider cycle boundary
	assign rise = src_level & ~src_q_r;
	assign wrap = (cnt_r >= ratio_r);
	assign cnt_nxt = wrap ? 8'h00 : 8'(cnt_r + 8'h01);
	assign ratio_nxt = wrap ? div_value : ratio_r;
	assign half = 9'(({1'b0, ratio_nxt} + 9'h002) >> 1);

	// ****************************************************
	// counter
	// ****************************************************
	// ratio is value plus one
	// new ratio taken only at wrap, no runt
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			src_q_r <= 1'b0;
			cnt_r <= 8'h00;
			ratio_r <= DIV4_RESET;
		end
		else if (ce)
		begin
			src_q_r <= src_level;
			if (rise)
			begin
				cnt_r <= cnt_nxt;
				ratio_r <= ratio_nxt;
			end
		end
	end

	// ****************************************************
	// output
	// ****************************************************
	// divider only shapes the clock when not bypassed
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			clk_out <= 1'b0;
		else if (ce)
		begin
			if (bypass || ratio_r == 8'h00)
				clk_out <= src_level;
			else if (rise)
				clk_out <= ({1'b0, cnt_nxt} < half);
		end
	end

	AST_DIV_LOAD: assert property (
		@(posedge clk) disable iff (reset)
		$changed(ratio_r) |-> $past(rise && wrap && ce))
		else $error("divider ratio changed off a cycle boundary");

	AST_DIV_RANGE: assert property (
		@(posedge clk) disable iff (reset)
		(ce && rise && !wrap) |=> cnt_r == $past(cnt_r) + 8'h01)
		else $error("divider count did not advance by one");

endmodule

// ### design/ocsd_top.sv
/*
 * Output channel source select and divider for channels 4 and 5,
 * driver control for channel 5, with an AXI4-Lite register slave.
 * Assumes all source levels, the doubler enable, the channel 4
 * source select and the channel 5 divider value are synchronous
 * inputs from logic outside this block.
 */
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps

// How it works
// - the channel 4 divider is an 8-bit value N giving ratio N+1.
// - a divider only acts when its channel takes the PLL source.
// - source code 0 is PLL, 1 reserved, 2 primary, 3 secondary ref.
// - with the doubler on, reference choices carry the doubled clock.
// - driver type 0 off, 1 AC differential, 2 HCSL, 3 CMOS; reset 1.
// - drive option A sits in bits 3 to 2 and resets to 2.
// - option A is tail current in differential or P pin in CMOS.
// - option B in bits 1 to 0 is HCSL load or N pin in CMOS.
module ocsd_top
	import ocsd_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic pll_clk,
	input wire logic pri_ref,
	input wire logic sec_ref,
	input wire logic pri_ref_x2,
	input wire logic sec_ref_x2,
	input wire logic ref_doubler_en,
	input wire logic [1:0] ch4_source_select,
	input wire logic [7:0] ch5_divider_value,
	output logic ch4_clk_out,
	output ocsd_drv_s ch5_drv,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// register address to selector
	function automatic logic [1:0] reg_decode(input logic [ADDR_W-1:0] a);
		if (a == ADDR_DIV4)
			reg_decode = SEL_DIV4;
		else if (a == ADDR_CTL5)
			reg_decode = SEL_CTL5;
		else if (a == ADDR_STAT)
			reg_decode = SEL_STAT;
		else
			reg_decode = SEL_NONE;
	endfunction

	function automatic logic src_pick(input logic [1:0] s,
		input logic pll, input logic pri, input logic sec,
		input logic pri2, input logic sec2, input logic dbl);
		case (s)
			SRC_PLL: src_pick = pll;
			SRC_PRI: src_pick = dbl ? pri2 : pri;
			SRC_SEC: src_pick = dbl ? sec2 : sec;
			default: src_pick = 1'b0;
		endcase
	endfunction

	logic [7:0] ch4_div_r;
	logic [1:0] ch5_src_r;
	logic [1:0] ch5_drv_sel_r;
	logic [1:0] ch5_opt_a_r;
	logic [1:0] ch5_opt_b_r;
	ocsd_wr_e wr_state_r;
	logic aw_held_r;
	logic w_held_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [7:0] wdata_r;
	logic wstrb0_r;
	logic wr_commit;
	logic [1:0] wr_sel;
	logic [1:0] rd_sel;
	logic [7:0] rd_byte;
	logic [1:0] sel_req [2];
	logic [1:0] sel_eff_r [2];
	logic [7:0] div_val [2];
	logic src_lvl [2];
	logic ch_clk [2];
	logic [7:0] ctl5_word;
	logic [7:0] stat_word;

	assign ctl5_word = {ch5_src_r, ch5_drv_sel_r, ch5_opt_a_r, ch5_opt_b_r};
	assign stat_word = {sel_eff_r[1], sel_eff_r[0], 2'h0,
		ch_clk[1], ch_clk[0]};

	// ****************************************************
	// AXI4-Lite write channel
	// ****************************************************
	// address and data are held apart so either may come first
	assign s_axi_awready = (wr_state_r == WR_TAKE) && !aw_held_r;
	assign s_axi_wready = (wr_state_r == WR_TAKE) && !w_held_r;
	assign s_axi_bvalid = (wr_state_r == WR_RESP);
	assign wr_commit = (wr_state_r == WR_TAKE) && aw_held_r && w_held_r;
	assign wr_sel = reg_decode(awaddr_r);

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wr_state_r <= WR_TAKE;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 8'h00;
			wstrb0_r <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata[7:0];
				wstrb0_r <= s_axi_wstrb[0];
			end
			case (wr_state_r)
				WR_TAKE:
					if (wr_commit)
					begin
						wr_state_r <= WR_RESP;
						s_axi_bresp <= (wr_sel == SEL_NONE) ?
							RESP_SLVERR : RESP_OKAY;
					end
				WR_RESP:
					if (s_axi_bready)
					begin
						wr_state_r <= WR_TAKE;
						aw_held_r <= 1'b0;
						w_held_r <= 1'b0;
					end
				default: wr_state_r <= WR_TAKE;
			endcase
		end
	end

	// ****************************************************
	// configuration registers
	// ****************************************************
	// driver type resets to differential
	// option A field resets to 2
	// option B field resets to 0
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ch4_div_r <= DIV4_RESET;
			ch5_src_r <= SRC5_RESET;
			ch5_drv_sel_r <= DRV5_RESET;
			ch5_opt_a_r <= OPTA5_RESET;
			ch5_opt_b_r <= OPTB5_RESET;
		end
		else if (ce && wr_commit && wstrb0_r)
		begin
			if (wr_sel == SEL_DIV4)
				ch4_div_r <= wdata_r;
			else if (wr_sel == SEL_CTL5)
			begin
				ch5_src_r <= wdata_r[CTL_SRC_LSB +: 2];
				ch5_drv_sel_r <= wdata_r[CTL_DRV_LSB +: 2];
				ch5_opt_a_r <= wdata_r[CTL_OPTA_LSB +: 2];
				ch5_opt_b_r <= wdata_r[CTL_OPTB_LSB +: 2];
			end
		end
	end

	// ****************************************************
	// AXI4-Lite read channel
	// ****************************************************
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_sel = reg_decode(s_axi_araddr);
	assign rd_byte = (rd_sel == SEL_DIV4) ? ch4_div_r :
		(rd_sel == SEL_CTL5) ? ctl5_word :
		(rd_sel == SEL_STAT) ? stat_word : 8'h00;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= (rd_sel == SEL_NONE) ?
					RESP_SLVERR : RESP_OKAY;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************************
	// clock paths
	// ****************************************************
	assign sel_req[0] = ch4_source_select;
	assign sel_req[1] = ch5_src_r;
	assign div_val[0] = ch4_div_r;
	assign div_val[1] = ch5_divider_value;

	for (genvar i = 0; i < 2; i++)
	begin : g_path
		assign src_lvl[i] = src_pick(sel_eff_r[i], pll_clk, pri_ref,
			sec_ref, pri_ref_x2, sec_ref_x2, ref_doubler_en);

		// switch source only while output is low
		// a source stuck high holds off the switch; accepted trade
		always_ff @(posedge clk or posedge reset)
		begin
			if (reset)
				sel_eff_r[i] <= SRC_PLL;
			else if (ce && !ch_clk[i])
				sel_eff_r[i] <= sel_req[i];
		end

		ocsd_divider ocsd_divider_inst (
			.clk(clk),
			.reset(reset),
			.ce(ce),
			.src_level(src_lvl[i]),
			.div_value(div_val[i]),
			.bypass(sel_eff_r[i] != SRC_PLL),
			.clk_out(ch_clk[i])
		);
	end

	assign ch4_clk_out = ch_clk[0];

	// ****************************************************
	// channel 5 driver
	// ****************************************************
	// driver type decode
	// option A as tail current or P pin
	// option B as HCSL load or N pin
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			ch5_drv <= '0;
		else if (ce)
		begin
			ch5_drv.tail_code <= ch5_opt_a_r;
			ch5_drv.load_code <= ch5_opt_b_r;
			ch5_drv.out_p <= ch_clk[1];
			ch5_drv.out_n <= ~ch_clk[1];
			case (ch5_drv_sel_r)
				DRV_OFF:
				begin
					ch5_drv.oe_p <= 1'b0;
					ch5_drv.oe_n <= 1'b0;
				end
				DRV_DIFF:
				begin
					ch5_drv.oe_p <= 1'b1;
					ch5_drv.oe_n <= 1'b1;
				end
				DRV_HCSL:
				begin
					ch5_drv.oe_p <= (ch5_opt_b_r != PIN_TRI);
					ch5_drv.oe_n <= (ch5_opt_b_r != PIN_TRI);
				end
				default:
				begin
					ch5_drv.oe_p <= (ch5_opt_a_r != PIN_TRI);
					ch5_drv.oe_n <= (ch5_opt_b_r != PIN_TRI);
					ch5_drv.out_p <= (ch5_opt_a_r == PIN_NORM) ? ch_clk[1] :
						(ch5_opt_a_r == PIN_INV) ? ~ch_clk[1] : 1'b0;
					ch5_drv.out_n <= (ch5_opt_b_r == PIN_NORM) ? ch_clk[1] :
						(ch5_opt_b_r == PIN_INV) ? ~ch_clk[1] : 1'b0;
				end
			endcase
		end
	end

	AST_DIV_WRITE: assert property (
		@(posedge clk) disable iff (reset)
		(ce && wr_commit && wstrb0_r && wr_sel == SEL_DIV4)
		|=> ch4_div_r == $past(wdata_r) && s_axi_bvalid)
		else $error("divider write not stored");

	AST_BYPASS: assert property (
		@(posedge clk) disable iff (reset)
		(ce && sel_eff_r[1] != SRC_PLL) |=> ch_clk[1] == $past(src_lvl[1]))
		else $error("reference path not bypassing divider");

	AST_REF_DBL: assert property (
		@(posedge clk) disable iff (reset)
		(ce && sel_eff_r[1] == SRC_PRI && ref_doubler_en)
		|=> ch_clk[1] == $past(pri_ref_x2))
		else $error("doubled reference not delivered");

	AST_RSVD_LOW: assert property (
		@(posedge clk) disable iff (reset)
		(ce && sel_eff_r[1] == SRC_RSVD) [*2] |-> !ch_clk[1])
		else $error("reserved source not held low");

	AST_DRV_OFF: assert property (
		@(posedge clk) disable iff (reset)
		(ce && ch5_drv_sel_r == DRV_OFF) |=> !ch5_drv.oe_p && !ch5_drv.oe_n)
		else $error("disabled driver still enabled");

	AST_TAIL: assert property (
		@(posedge clk) disable iff (reset)
		(ce && ch5_drv_sel_r == DRV_DIFF)
		|=> ch5_drv.tail_code == $past(ch5_opt_a_r) && ch5_drv.oe_p)
		else $error("tail current code mismatch");

	AST_CMOS_LOW: assert property (
		@(posedge clk) disable iff (reset)
		(ce && ch5_drv_sel_r == DRV_CMOS && ch5_opt_a_r == PIN_LOW)
		|=> ch5_drv.oe_p && !ch5_drv.out_p)
		else $error("cmos P pin not driven low");

	AST_HCSL_TRI: assert property (
		@(posedge clk) disable iff (reset)
		(ce && ch5_drv_sel_r == DRV_HCSL && ch5_opt_b_r == PIN_TRI)
		|=> !ch5_drv.oe_p && !ch5_drv.oe_n)
		else $error("hcsl tristate load still driving");

	AST_SRC_SWITCH: assert property (
		@(posedge clk) disable iff (reset)
		$changed(sel_eff_r[1]) |-> $past(!ch_clk[1]))
		else $error("source switched while output high");

endmodule

// ### dv/tb_ocsd_top.sv
/*
 * Self-checking bench for the output channel source and divider block:
 * register reset values and access, channel 4 divide ratios, source
 * selection with and without the doubler, and driver mode decoding.
 * Assumes the package constants and the hand-over bus timing.
 */
`timescale 1ns/1ps
module tb_ocsd_top;
	import ocsd_pkg::*;
	logic clk, reset, ce, pll_clk, pri_ref, sec_ref;
	logic pri_ref_x2, sec_ref_x2, ref_doubler_en, ch4_clk_out;
	logic [1:0] ch4_source_select;
	logic [7:0] ch5_divider_value, sc;
	ocsd_drv_s ch5_drv;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] rdv;
	int n_fail, checks_done, cyc;

	ocsd_top ocsd_top_inst (.clk(clk), .reset(reset), .ce(ce),
		.pll_clk(pll_clk), .pri_ref(pri_ref), .sec_ref(sec_ref),
		.pri_ref_x2(pri_ref_x2), .sec_ref_x2(sec_ref_x2),
		.ref_doubler_en(ref_doubler_en),
		.ch4_source_select(ch4_source_select),
		.ch5_divider_value(ch5_divider_value),
		.ch4_clk_out(ch4_clk_out), .ch5_drv(ch5_drv),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));

	// ****************************************************
	// clock, source levels and watchdog
	// ****************************************************
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// sources of periods 2, 4, 8, 16 and 32 clocks, all distinct
	always @(posedge clk)
	begin
		sc <= sc + 8'h01;
		pll_clk <= sc[0];
		pri_ref_x2 <= sc[1];
		pri_ref <= sc[2];
		sec_ref_x2 <= sc[3];
		sec_ref <= sc[4];
	end

	// the whole run needs well under ten thousand cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			n_fail = n_fail + 1;
			finish_test();
		end
	end

	// ****************************************************
	// shared tasks
	// ****************************************************
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done = checks_done + 1;
		if (g !== e)
		begin
			n_fail = n_fail + 1;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	// handshakes are judged at the falling edge, where inputs are settled
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic ta, tw, done;
		done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		while (!done)
		begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			done = (s_axi_bvalid === 1'b1);
			r = s_axi_bresp;
			@(posedge clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
		end
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ta, done;
		done = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (!done)
		begin
			@(negedge clk);
			ta = s_axi_arvalid && s_axi_arready;
			done = (s_axi_rvalid === 1'b1);
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ta)
				s_axi_arvalid <= 1'b0;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_write(a, d, 4'hF, rsp);
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a,
		input logic [31:0] e, input logic [1:0] er);
		axi_read(a, rdv, rsp);
		chk(nm, e, rdv);
		chk(nm, {30'h0, er}, {30'h0, rsp});
	endtask

	function automatic logic sig(input logic c);
		return c ? ch5_drv.out_p : ch4_clk_out;
	endfunction

	// third period is kept: the first ones may span a ratio change
	// a period is counted from one first-high sample to the next
	task automatic meas(input logic c, input int e, input string nm);
		int n, lim;
		lim = 0;
		n = 0;
		while (sig(c) !== 1'b0 && lim < 3000)
		begin
			@(negedge clk);
			lim++;
		end
		while (sig(c) !== 1'b1 && lim < 3000)
		begin
			@(negedge clk);
			lim++;
		end
		for (int k = 0; k < 3; k++)
		begin
			n = 0;
			while (sig(c) !== 1'b0 && lim < 3000)
			begin
				@(negedge clk);
				n++;
				lim++;
			end
			while (sig(c) !== 1'b1 && lim < 3000)
			begin
				@(negedge clk);
				n++;
				lim++;
			end
		end
		chk(nm, e, n);
		@(posedge clk);
	endtask

	// the switch waits for a low output, so let a high phase finish
	task automatic quiet(input logic c, input string nm);
		int n;
		n = 0;
		repeat (24) @(posedge clk);
		repeat (50)
		begin
			@(negedge clk);
			if (sig(c) !== 1'b0)
				n++;
		end
		chk(nm, 0, n);
		@(posedge clk);
	endtask

	// ****************************************************
	// scenarios
	// ****************************************************
	task automatic t_regs;
		rd_chk("div4 reset", ADDR_DIV4, 32'h02, RESP_OKAY);
		rd_chk("ctl5 reset", ADDR_CTL5, 32'h18, RESP_OKAY);
		@(negedge clk);
		chk("drv reset", 32'h38, {26'h0, ch5_drv.oe_p, ch5_drv.oe_n,
			ch5_drv.tail_code, ch5_drv.load_code});
		chk("drv reset pn", 32'h1,
			{31'h0, ch5_drv.out_p ^ ch5_drv.out_n});
		@(posedge clk);
		wr(ADDR_DIV4, 32'hA5);
		axi_write(ADDR_DIV4, 32'h11, 4'hE, rsp);
		chk("nostrb bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
		rd_chk("div4 rw", ADDR_DIV4, 32'hA5, RESP_OKAY);
		axi_write(8'h00, 32'h55, 4'hF, rsp);
		chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		rd_chk("unmapped", 8'h00, 32'h0, RESP_SLVERR);
		$display("register test done");
	endtask

	task automatic t_div4;
		logic [7:0] nv[4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
		ch4_source_select <= SRC_PLL;
		foreach (nv[i])
		begin
			wr(ADDR_DIV4, {24'h0, nv[i]});
			meas(1'b0, 2 * (nv[i] + 1), "ch4 pll period");
		end
		$display("divider test done");
	endtask

	// clock enable low must freeze the running channel 5 output
	task automatic t_hold;
		logic v;
		int n;
		ce <= 1'b0;
		@(negedge clk);
		v = ch5_drv.out_p;
		n = 0;
		repeat (20)
		begin
			@(negedge clk);
			if (ch5_drv.out_p !== v)
				n++;
		end
		chk("ce hold", 0, n);
		@(posedge clk);
		ce <= 1'b1;
		$display("clock enable test done");
	endtask

	// divider left at 255 (ratio 256): a reference choice must bypass it
	task automatic t_src;
		ch4_source_select <= SRC_PRI;
		meas(1'b0, 8, "ch4 pri");
		ref_doubler_en <= 1'b1;
		meas(1'b0, 4, "ch4 pri x2");
		ch4_source_select <= SRC_SEC;
		meas(1'b0, 16, "ch4 sec x2");
		ch4_source_select <= SRC_RSVD;
		quiet(1'b0, "ch4 reserved");
		ch5_divider_value <= 8'h03;
		meas(1'b1, 8, "ch5 pll");
		t_hold();
		wr(ADDR_CTL5, 32'h98);
		meas(1'b1, 4, "ch5 pri x2");
		ref_doubler_en <= 1'b0;
		wr(ADDR_CTL5, 32'hD8);
		meas(1'b1, 32, "ch5 sec");
		wr(ADDR_CTL5, 32'h58);
		quiet(1'b1, "ch5 reserved");
		rd_chk("ctl5 rw", ADDR_CTL5, 32'h58, RESP_OKAY);
		wr(ADDR_STAT, 32'hFF);
		rd_chk("stat", ADDR_STAT, 32'h50, RESP_OKAY);
		$display("source test done");
	endtask

	// every driver type against every pair of drive options
	task automatic t_drv;
		logic [1:0] t, a, b;
		logic op, on;
		for (int i = 0; i < 64; i++)
		begin
			{t, a, b} = 6'(i);
			wr(ADDR_CTL5, {26'h0, t, a, b});
			repeat (2) @(posedge clk);
			op = (t == DRV_DIFF) || (t == DRV_HCSL && b != 0);
			op = op || (t == DRV_CMOS && a != 0);
			on = (t == DRV_DIFF) || (t != DRV_OFF && b != 0);
			@(negedge clk);
			chk("drv oe tail load", {26'h0, op, on, a, b},
				{26'h0, ch5_drv.oe_p, ch5_drv.oe_n,
				ch5_drv.tail_code, ch5_drv.load_code});
			if (t == DRV_CMOS && b == PIN_LOW)
				chk("cmos n low", 32'h0, {31'h0, ch5_drv.out_n});
			@(posedge clk);
		end
		$display("driver test done");
	endtask

	task finish_test;
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************************************************
	// main sequence
	// ****************************************************
	initial
	begin
		{n_fail, checks_done, cyc} = '0;
		{reset, ce, sc, ref_doubler_en} = {1'b1, 1'b1, 8'h00, 1'b0};
		{pll_clk, pri_ref, sec_ref, pri_ref_x2, sec_ref_x2} = '0;
		{ch4_source_select, ch5_divider_value} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_bready, s_axi_rready} = 2'b11;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_regs();
		t_div4();
		t_src();
		t_drv();
		finish_test();
	end
endmodule
